//--- rtl/dsp_pkg.sv
// Constants, types and helpers shared by the dual serial register port
// ==========================================================================
package dsp_pkg;

  // ==========================================================================
  // Widths and fixed codes
  localparam int          DSP_IDX_W        = 7;
  localparam int          DSP_BYTE_W       = 8;
  localparam logic [5:0]  DSP_TARGET_HI    = 6'h2e;
  localparam logic [2:0]  DSP_LAST_BIT     = 3'h7;
  localparam logic [3:0]  DSP_BYTE_BITS    = 4'h8;
  localparam int          DSP_CMD_RW_POS   = 7;
  localparam int          DSP_CMD_STEP_POS = 6;
  localparam int          DSP_IDX_STEP_POS = 7;

  // ==========================================================================
  // Timing
  localparam int          DSP_CLK_PERIOD_NS = 10;
  localparam int          DSP_GLITCH_NS     = 50;
  localparam int          DSP_FILT_INT      =
    (DSP_GLITCH_NS + DSP_CLK_PERIOD_NS - 1) / DSP_CLK_PERIOD_NS;
  localparam logic [2:0]  DSP_FILT_CYCLES   = 3'(DSP_FILT_INT);

  // ==========================================================================
  // Two-wire protocol states
  typedef enum logic [3:0] {
    DSP_IDLE      = 4'h0,
    DSP_ADDR      = 4'h1,
    DSP_ADDR_ACK  = 4'h3,
    DSP_INDEX     = 4'h2,
    DSP_INDEX_ACK = 4'h6,
    DSP_WRITE     = 4'h7,
    DSP_WRITE_ACK = 4'h5,
    DSP_READ      = 4'h4,
    DSP_READ_ACK  = 4'hc
  } dsp_state_t;

  // Index advance, wraps inside the register space
  function automatic logic [DSP_IDX_W-1:0] dsp_step_index(
    input logic [DSP_IDX_W-1:0] idx,
    input logic                 en
  );
    dsp_step_index = en ? DSP_IDX_W'(idx + 7'h01) : idx;
  endfunction

endpackage

//--- rtl/dsp_port.sv
// Dual serial register port: two-wire target and serial peripheral target
`timescale 1ns/1ps
`default_nettype none
module dsp_port
  import dsp_pkg::*;
(
  // System clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_b_i,
  // Serial pins
  input  wire logic                          cs_b_i,
  input  wire logic                          serial_port_clock_i,
  input  wire logic                          sda_i,
  output logic                               sda_o,
  output logic                               sda_oe_o,
  input  wire logic                          addr_low_select_i,
  output logic                               serial_out_o,
  output logic                               serial_out_oe_o,
  // Configuration
  input  wire logic                          three_wire_select_i,
  // Register write port, system clock
  output logic                               wr_en_o,
  output logic [dsp_pkg::DSP_IDX_W-1:0]      wr_addr_o,
  output logic [dsp_pkg::DSP_BYTE_W-1:0]     wr_data_o,
  // Register read port, system clock
  output logic [dsp_pkg::DSP_IDX_W-1:0]      rd_addr_o,
  input  wire logic [dsp_pkg::DSP_BYTE_W-1:0] rd_data_i,
  // Register read port, serial port clock
  output logic [dsp_pkg::DSP_IDX_W-1:0]      spi_rd_addr_o,
  input  wire logic [dsp_pkg::DSP_BYTE_W-1:0] spi_rd_data_i,
  // Status
  output logic                               bus_busy_o,
  output logic                               addressed_o
);
  import dsp_pkg::*;

  // ==========================================================================
  // Pin synchronisers and glitch filter, system clock
  logic [1:0] line_s1_reg;
  logic [1:0] line_s2_reg;
  logic [1:0] line_f_reg;
  logic [1:0] line_prev_reg;
  logic [2:0] filt_cnt_reg [2];
  logic       cs_s1_reg;
  logic       cs_s2_reg;
  logic       sel_s1_reg;
  logic       sel_s2_reg;

  // Index 0 is clock, index 1 is data; first stage read only by second
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      line_s1_reg <= 2'h3;
      line_s2_reg <= 2'h3;
      cs_s1_reg   <= 1'b1;
      cs_s2_reg   <= 1'b1;
      sel_s1_reg  <= 1'b0;
      sel_s2_reg  <= 1'b0;
    end
    else
    begin
      line_s1_reg <= {sda_i, serial_port_clock_i};
      line_s2_reg <= line_s1_reg;
      cs_s1_reg   <= cs_b_i;
      cs_s2_reg   <= cs_s1_reg;
      sel_s1_reg  <= addr_low_select_i;
      sel_s2_reg  <= sel_s1_reg;
    end
  end

  // A level must hold a whole filter window before it is believed
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      line_f_reg    <= 2'h3;
      line_prev_reg <= 2'h3;
      filt_cnt_reg  <= '{3'h0, 3'h0};
    end
    else
    begin
      line_prev_reg <= line_f_reg;
      for (int i = 0; i < 2; i++)
      begin
        if (line_s2_reg[i] == line_f_reg[i])
          filt_cnt_reg[i] <= 3'h0;
        else if (filt_cnt_reg[i] == DSP_FILT_CYCLES - 3'h1)
        begin
          line_f_reg[i]   <= line_s2_reg[i];
          filt_cnt_reg[i] <= 3'h0;
        end
        else
          filt_cnt_reg[i] <= filt_cnt_reg[i] + 3'h1;
      end
    end
  end

  // ==========================================================================
  // Bus conditions
  logic i2c_mode;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic sda_f;

  assign i2c_mode   = cs_s2_reg;
  assign sda_f      = line_f_reg[1];
  assign scl_rise   = line_f_reg[0] & ~line_prev_reg[0];
  assign scl_fall   = ~line_f_reg[0] & line_prev_reg[0];
  assign start_seen = i2c_mode & line_f_reg[0] & line_prev_reg[0]
                      & line_prev_reg[1] & ~sda_f;
  assign stop_seen  = i2c_mode & line_f_reg[0] & line_prev_reg[0]
                      & ~line_prev_reg[1] & sda_f;

  // ==========================================================================
  // Two-wire target state machine
  dsp_state_t                state_reg;
  logic [3:0]                bit_cnt_reg;
  logic [DSP_BYTE_W-1:0]     rx_reg;
  logic [DSP_BYTE_W-1:0]     tx_reg;
  logic [DSP_IDX_W-1:0]      index_reg;
  logic                      step_reg;
  logic                      read_dir_reg;
  logic                      pull_reg;
  logic                      ctl_nack_reg;
  logic                      i2c_wr_reg;
  logic [DSP_BYTE_W-1:0]     i2c_wdata_reg;
  logic [DSP_IDX_W-1:0]      i2c_waddr_reg;
  logic                      busy_reg;
  logic                      addressed_reg;
  logic                      byte_done;
  logic [DSP_IDX_W-1:0]      own_addr;

  assign own_addr  = {DSP_TARGET_HI, sel_s2_reg};
  assign byte_done = (bit_cnt_reg == DSP_BYTE_BITS);

  // Bits are shifted in on each rising clock; the acknowledge clock is
  // counted but not shifted, so the next byte starts aligned
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      rx_reg      <= 8'h00;
      bit_cnt_reg <= 4'h0;
    end
    else if (start_seen || !i2c_mode)
      bit_cnt_reg <= 4'h0;
    else if (scl_rise && bit_cnt_reg < DSP_BYTE_BITS)
    begin
      rx_reg      <= {rx_reg[DSP_BYTE_W-2:0], sda_f};
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
    else if (scl_rise && byte_done)
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    else if (scl_fall && bit_cnt_reg > DSP_BYTE_BITS)
      bit_cnt_reg <= 4'h0;
  end

  // Busy between start and stop
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      busy_reg <= 1'b0;
    else if (start_seen)
      busy_reg <= 1'b1;
    else if (stop_seen || !i2c_mode)
      busy_reg <= 1'b0;
  end

  // Answers are driven a filter delay after the falling clock, inside the
  // low phase, so the register file never needs to stretch the clock
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      state_reg     <= DSP_IDLE;
      tx_reg        <= 8'h00;
      index_reg     <= 7'h00;
      step_reg      <= 1'b0;
      read_dir_reg  <= 1'b0;
      pull_reg      <= 1'b0;
      ctl_nack_reg  <= 1'b1;
      i2c_wr_reg    <= 1'b0;
      i2c_wdata_reg <= 8'h00;
      i2c_waddr_reg <= 7'h00;
      addressed_reg <= 1'b0;
    end
    else
    begin
      i2c_wr_reg <= 1'b0;
      if (!i2c_mode || stop_seen)
      begin
        state_reg     <= DSP_IDLE;
        pull_reg      <= 1'b0;
        addressed_reg <= 1'b0;
      end
      else if (start_seen)
      begin
        state_reg     <= DSP_ADDR;
        pull_reg      <= 1'b0;
        addressed_reg <= 1'b0;
      end
      else
      begin
        case (state_reg)
          DSP_ADDR:
            if (scl_fall && byte_done)
            begin
              if (rx_reg[DSP_BYTE_W-1:1] == own_addr)
              begin
                state_reg     <= DSP_ADDR_ACK;
                read_dir_reg  <= rx_reg[0];
                pull_reg      <= 1'b1;
                addressed_reg <= 1'b1;
              end
              else
                state_reg <= DSP_IDLE;
            end
          DSP_ADDR_ACK:
            if (scl_fall)
            begin
              if (read_dir_reg)
              begin
                state_reg <= DSP_READ;
                tx_reg    <= {rd_data_i[DSP_BYTE_W-2:0], 1'b0};
                pull_reg  <= ~rd_data_i[DSP_BYTE_W-1];
              end
              else
              begin
                state_reg <= DSP_INDEX;
                pull_reg  <= 1'b0;
              end
            end
          DSP_INDEX:
            if (scl_fall && byte_done)
            begin
              state_reg <= DSP_INDEX_ACK;
              index_reg <= rx_reg[DSP_IDX_W-1:0];
              step_reg  <= rx_reg[DSP_IDX_STEP_POS];
              pull_reg  <= 1'b1;
            end
          DSP_INDEX_ACK:
            if (scl_fall)
            begin
              state_reg <= DSP_WRITE;
              pull_reg  <= 1'b0;
            end
          DSP_WRITE:
            if (scl_fall && byte_done)
            begin
              state_reg     <= DSP_WRITE_ACK;
              i2c_wr_reg    <= 1'b1;
              i2c_wdata_reg <= rx_reg;
              i2c_waddr_reg <= index_reg;
              index_reg     <= dsp_step_index(index_reg, step_reg);
              pull_reg      <= 1'b1;
            end
          DSP_WRITE_ACK:
            if (scl_fall)
            begin
              state_reg <= DSP_WRITE;
              pull_reg  <= 1'b0;
            end
          DSP_READ:
            if (scl_fall)
            begin
              if (byte_done)
              begin
                state_reg <= DSP_READ_ACK;
                pull_reg  <= 1'b0;
                index_reg <= dsp_step_index(index_reg, step_reg);
              end
              else
              begin
                tx_reg   <= {tx_reg[DSP_BYTE_W-2:0], 1'b0};
                pull_reg <= ~tx_reg[DSP_BYTE_W-1];
              end
            end
          DSP_READ_ACK:
            if (scl_rise)
              ctl_nack_reg <= sda_f;
            else if (scl_fall)
            begin
              if (!ctl_nack_reg)
              begin
                state_reg <= DSP_READ;
                tx_reg    <= {rd_data_i[DSP_BYTE_W-2:0], 1'b0};
                pull_reg  <= ~rd_data_i[DSP_BYTE_W-1];
              end
              else
                state_reg <= DSP_IDLE;
            end
          default:
            pull_reg <= 1'b0;
        endcase
      end
    end
  end

  // ==========================================================================
  // Serial peripheral logic, serial port clock domain, cleared by the frame
  logic [DSP_BYTE_W-1:0] spi_sh_reg;
  logic [2:0]            spi_cnt_reg;
  logic                  spi_cmd_reg;
  logic                  spi_rd_reg;
  logic                  spi_step_reg;
  logic [5:0]            spi_addr_reg;
  logic [DSP_BYTE_W-1:0] spi_sh_next;
  logic [DSP_BYTE_W-1:0] spi_out_reg;
  logic                  spi_drive_reg;
  logic                  tw_s1_reg;
  logic                  tw_s2_reg;

  assign spi_sh_next   = {spi_sh_reg[DSP_BYTE_W-2:0], sda_i};
  assign spi_rd_addr_o = {1'b0, spi_addr_reg};

  always_ff @(posedge serial_port_clock_i or posedge cs_b_i)
  begin
    if (cs_b_i)
    begin
      spi_sh_reg   <= 8'h00;
      spi_cnt_reg  <= 3'h0;
      spi_cmd_reg  <= 1'b0;
      spi_rd_reg   <= 1'b0;
      spi_step_reg <= 1'b0;
      spi_addr_reg <= 6'h00;
      tw_s1_reg    <= 1'b0;
      tw_s2_reg    <= 1'b0;
    end
    else
    begin
      tw_s1_reg   <= three_wire_select_i;
      tw_s2_reg   <= tw_s1_reg;
      spi_sh_reg  <= spi_sh_next;
      spi_cnt_reg <= spi_cnt_reg + 3'h1;
      if (spi_cnt_reg == DSP_LAST_BIT)
      begin
        if (!spi_cmd_reg)
        begin
          spi_cmd_reg  <= 1'b1;
          spi_rd_reg   <= spi_sh_next[DSP_CMD_RW_POS];
          spi_step_reg <= spi_sh_next[DSP_CMD_STEP_POS];
          spi_addr_reg <= spi_sh_next[5:0];
        end
        else
          spi_addr_reg <= 6'(dsp_step_index({1'b0, spi_addr_reg}, spi_step_reg));
      end
    end
  end

  // Write events leave the frame domain through a toggle; held data stays
  // put for a whole byte, far longer than the system side needs
  logic                  spi_tog_reg;
  logic [DSP_BYTE_W-1:0] spi_wdata_reg;
  logic [DSP_IDX_W-1:0]  spi_waddr_reg;

  always_ff @(posedge serial_port_clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      spi_tog_reg   <= 1'b0;
      spi_wdata_reg <= 8'h00;
      spi_waddr_reg <= 7'h00;
    end
    else if (!cs_b_i && spi_cnt_reg == DSP_LAST_BIT && spi_cmd_reg && !spi_rd_reg)
    begin
      spi_tog_reg   <= ~spi_tog_reg;
      spi_wdata_reg <= spi_sh_next;
      spi_waddr_reg <= {1'b0, spi_addr_reg};
    end
  end

  // Read bytes launched on the falling edge that opens each data block
  always_ff @(negedge serial_port_clock_i or posedge cs_b_i)
  begin
    if (cs_b_i)
    begin
      spi_out_reg   <= 8'h00;
      spi_drive_reg <= 1'b0;
    end
    else if (spi_cmd_reg && spi_rd_reg && spi_cnt_reg == 3'h0)
    begin
      spi_out_reg   <= spi_rd_data_i;
      spi_drive_reg <= 1'b1;
    end
    else
      spi_out_reg <= {spi_out_reg[DSP_BYTE_W-2:0], 1'b0};
  end

  // ==========================================================================
  // Write crossing into the system clock
  logic tog_s1_reg;
  logic tog_s2_reg;
  logic tog_s3_reg;
  logic wr_en_reg;
  logic [DSP_IDX_W-1:0]  wr_addr_reg;
  logic [DSP_BYTE_W-1:0] wr_data_reg;

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      tog_s1_reg <= 1'b0;
      tog_s2_reg <= 1'b0;
      tog_s3_reg <= 1'b0;
    end
    else
    begin
      tog_s1_reg <= spi_tog_reg;
      tog_s2_reg <= tog_s1_reg;
      tog_s3_reg <= tog_s2_reg;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      wr_en_reg   <= 1'b0;
      wr_addr_reg <= 7'h00;
      wr_data_reg <= 8'h00;
    end
    else if (tog_s2_reg != tog_s3_reg)
    begin
      wr_en_reg   <= 1'b1;
      wr_addr_reg <= spi_waddr_reg;
      wr_data_reg <= spi_wdata_reg;
    end
    else
    begin
      wr_en_reg   <= i2c_wr_reg;
      wr_addr_reg <= i2c_waddr_reg;
      wr_data_reg <= i2c_wdata_reg;
    end
  end

  // ==========================================================================
  // Outputs
  always_comb
  begin
    sda_o           = 1'b0;
    sda_oe_o        = pull_reg & i2c_mode;
    serial_out_o    = spi_out_reg[DSP_BYTE_W-1];
    serial_out_oe_o = spi_drive_reg & ~tw_s2_reg;
    if (spi_drive_reg && tw_s2_reg)
    begin
      sda_o    = spi_out_reg[DSP_BYTE_W-1];
      sda_oe_o = 1'b1;
    end
  end

  assign wr_en_o     = wr_en_reg;
  assign wr_addr_o   = wr_addr_reg;
  assign wr_data_o   = wr_data_reg;
  assign rd_addr_o   = index_reg;
  assign bus_busy_o  = busy_reg;
  assign addressed_o = addressed_reg;

endmodule
`default_nettype wire

//--- testbench/dsp_ctl_model.sv
// Bus controller model for both serial modes
`timescale 1ns/1ps
`default_nettype none
module dsp_ctl_model (
  // Clock and lines
  input  wire logic clk_i,
  input  wire logic sda_i,
  input  wire logic sdo_i,
  input  wire logic three_wire_i,
  output logic      cs_b_o,
  output logic      scl_o,
  output logic      oe_o,
  output logic      val_o
);
  // Quarter bit of 630 ns keeps the rate just under 400 kHz
  localparam int Q = 63;
  logic [7:0] rx [2];

  initial
  begin
    cs_b_o = 1'b1;  // High selects two-wire
    scl_o = 1'b1;
    oe_o = 1'b0;
    val_o = 1'b0;
  end

  task automatic qw();
    repeat (Q) @(negedge clk_i);
  endtask

  task automatic i2c_bit(input logic b, output logic r);
    qw();
    oe_o = !b;  // Changes only while clock low
    qw();
    scl_o = 1'b1;
    qw();
    r = sda_i;
    qw();
    scl_o = 1'b0;
  endtask

  task automatic i2c_start();  // Also serves as repeated start
    qw();
    oe_o = 1'b0;
    qw();
    scl_o = 1'b1;
    qw();
    oe_o = 1'b1;
    qw();
    scl_o = 1'b0;
  endtask

  task automatic i2c_stop();
    qw();
    oe_o = 1'b1;
    qw();
    scl_o = 1'b1;
    qw();
    oe_o = 1'b0;
    qw();
  endtask

  task automatic i2c_byte(input logic [7:0] tx, input logic ack, output logic [7:0] rb,
                          output logic ack_seen);
    for (int i = 7; i >= 0; i--)
      i2c_bit(tx[i], rb[i]);  // MSB first
    i2c_bit(ack, ack_seen);  // High on the last read byte
  endtask

  // Link clock of 30 ns made only inside the frame
  task automatic spi_frame(input logic [7:0] cmd, input int n, input logic [7:0] tx [2]);
    cs_b_o = 1'b0;
    #23;
    for (int k = 0; k < 8 + 8 * n; k++)
    begin
      scl_o = 1'b0;
      oe_o = (k < 8) || !cmd[7];
      val_o = (k < 8) ? cmd[7 - k] : tx[k / 8 - 1][7 - k % 8];
      #15;
      scl_o = 1'b1;
      if (k >= 8)
        rx[k / 8 - 1][7 - k % 8] = three_wire_i ? sda_i : sdo_i;
      #15;
    end
    // Data released with the frame, or a held low looks like a start
    cs_b_o = 1'b1;
    oe_o = 1'b0;
    val_o = 1'b0;
    #50;
  endtask
endmodule
`default_nettype wire

//--- testbench/dsp_port_assertions.sv
// Protocol checker for the dual serial register port
`timescale 1ns/1ps
`default_nettype none
module dsp_chk (
  // Clock, reset and pins
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic cs_b_i,
  input wire logic serial_port_clock_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic serial_out_oe_o,
  input wire logic three_wire_select_i,
  // Status
  input wire logic wr_en_o,
  input wire logic bus_busy_o,
  input wire logic addressed_o
);
  // ========
  // Link-side bit counter, cleared while deselected
  logic [4:0] fall_cnt;
  logic       rd_cmd;

  always_ff @(negedge serial_port_clock_i or posedge cs_b_i)
  begin
    if (cs_b_i)
      fall_cnt <= 5'h00;
    else if (fall_cnt != 5'h1f)
      fall_cnt <= fall_cnt + 5'h01;
  end

  always_ff @(posedge serial_port_clock_i or posedge cs_b_i)
  begin
    if (cs_b_i)
      rd_cmd <= 1'b0;
    else if (fall_cnt == 5'h01)
      rd_cmd <= sda_i;
  end

  // ========
  // Two-wire conditions, held long enough to pass the filter
  sequence start_s;
    cs_b_i && serial_port_clock_i && $fell(sda_i) ##1
      (cs_b_i && serial_port_clock_i && !sda_i) [*8];
  endsequence

  sequence stop_s;
    cs_b_i && serial_port_clock_i && $rose(sda_i) ##1
      (cs_b_i && serial_port_clock_i && sda_i) [*8];
  endsequence

  busy_on_start_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    start_s |-> ##[0:8] bus_busy_o) else $error("busy not raised after start");
  idle_on_stop_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    stop_s |-> ##[0:8] (!bus_busy_o && !addressed_o)) else $error("not idle after stop");
  wr_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_en_o |=> !wr_en_o) else $error("write strobe longer than one cycle");
  open_drain_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cs_b_i && sda_oe_o |-> !sda_o) else $error("data line driven high in two-wire");
  ack_edge_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cs_b_i && $past(cs_b_i) && $changed(sda_oe_o) |-> !serial_port_clock_i)
    else $error("data drive changed while clock high");
  foreign_quiet_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (cs_b_i && !addressed_o) [*2] |-> !sda_oe_o) else $error("drive while unaddressed");
  mode_sel_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    serial_out_oe_o |-> (!cs_b_i && !three_wire_select_i)) else $error("wrong output pin");
  // Link domain: no drive before bit eight, only for reads
  spi_quiet_a: assert property (@(posedge serial_port_clock_i) disable iff (cs_b_i)
    fall_cnt < 5'h09 |-> (!serial_out_oe_o && !sda_oe_o)) else $error("early read drive");
  spi_drive_a: assert property (@(posedge serial_port_clock_i) disable iff (cs_b_i)
    (fall_cnt >= 5'h09 && rd_cmd) |-> (three_wire_select_i ? sda_oe_o : serial_out_oe_o))
    else $error("read data not driven");
  spi_wr_quiet_a: assert property (@(posedge serial_port_clock_i) disable iff (cs_b_i)
    !rd_cmd |-> (!serial_out_oe_o && !sda_oe_o)) else $error("drive during write");
endmodule

bind dsp_port dsp_chk chk_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b_i),
  .serial_port_clock_i(serial_port_clock_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .serial_out_oe_o(serial_out_oe_o),
  .three_wire_select_i(three_wire_select_i), .wr_en_o(wr_en_o),
  .bus_busy_o(bus_busy_o), .addressed_o(addressed_o));
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the dual serial register port
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk, rst_b, sel, tw, sdo_q;
  logic        cs_b, scl, c_oe, c_val, so, so_oe;
  logic        sda_o, sda_oe, wr_en, busy, hit;
  logic [6:0]  wr_addr, rd_addr, spi_addr;
  logic [7:0]  wr_data, rd_d, spi_d;
  logic [7:0]  tx [2];
  logic [14:0] wq [$];
  wire logic   sda, serial_out;
  int          n_fail, checks, cyc;

  // Register file stand-in
  function automatic logic [7:0] rv(input logic [6:0] x);
    return {x, 1'b0} ^ 8'h5b;
  endfunction

  assign rd_d = rv(rd_addr);
  assign spi_d = rv(spi_addr);
  // Pulled-up shared line; released output shows the inverse of its last bit
  assign sda = (sda_oe ? sda_o : 1'b1) & (c_oe ? c_val : 1'b1);
  assign serial_out = so_oe ? so : ~sdo_q;
  always @*
    if (so_oe)
      sdo_q = so;

  dsp_ctl_model m (.clk_i(clk), .sda_i(sda), .sdo_i(serial_out), .three_wire_i(tw),
    .cs_b_o(cs_b), .scl_o(scl), .oe_o(c_oe), .val_o(c_val));
  dsp_port dut_u (.clk_i(clk), .rst_b_i(rst_b), .cs_b_i(cs_b), .serial_port_clock_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_low_select_i(sel),
    .serial_out_o(so), .serial_out_oe_o(so_oe), .three_wire_select_i(tw),
    .wr_en_o(wr_en), .wr_addr_o(wr_addr), .wr_data_o(wr_data), .rd_addr_o(rd_addr),
    .rd_data_i(rd_d), .spi_rd_addr_o(spi_addr), .spi_rd_data_i(spi_d),
    .bus_busy_o(busy), .addressed_o(hit));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (wr_en === 1'b1)
      wq.push_back({wr_addr, wr_data});
    cyc++;
    if (cyc == 70000)
    begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic check(input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wb(input logic [7:0] d, input logic nak);
    logic [7:0] r;
    logic k;
    m.i2c_byte(d, 1'b1, r, k);
    check({15'h0, k}, {15'h0, nak});
  endtask

  task automatic rb(input logic [6:0] idx, input logic last);
    logic [7:0] r;
    logic k;
    m.i2c_byte(8'hff, last, r, k);
    check({8'h0, r}, {8'h0, rv(idx)});
  endtask

  task automatic ew(input logic [6:0] a, input logic [7:0] d);
    check(wq.size() > 0 ? {1'b0, wq.pop_front()} : 16'hffff, {1'b0, a, d});
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    rst_b = 1'b0;
    sel = 1'b1;
    tw = 1'b0;
    tx[0] = 8'ha1;
    tx[1] = 8'hb2;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    repeat (5) @(negedge clk);
    // ========
    // Two-wire stepped write across the index wrap
    m.i2c_start();
    check({15'h0, busy}, 16'h1);
    wb(8'hba, 1'b0);
    wb(8'hff, 1'b0);
    wb(8'h11, 1'b0);
    wb(8'h22, 1'b0);
    m.i2c_stop();
    check({14'h0, busy, hit}, 16'h0);
    ew(7'h7f, 8'h11);
    ew(7'h00, 8'h22);
    $display("test i2c_write done");
    // ========
    // Two-wire stepped read with repeated start, low address bit
    sel = 1'b0;
    m.i2c_start();
    wb(8'hb8, 1'b0);
    wb(8'h85, 1'b0);
    m.i2c_start();
    wb(8'hb9, 1'b0);
    rb(7'h05, 1'b0);
    rb(7'h06, 1'b0);
    rb(7'h07, 1'b1);
    m.i2c_stop();
    check(16'(wq.size()), 16'h0);
    $display("test i2c_read done");
    // ========
    // Fixed index write, then a foreign address
    m.i2c_start();
    wb(8'hb8, 1'b0);
    wb(8'h10, 1'b0);
    wb(8'hc3, 1'b0);
    wb(8'h3c, 1'b0);
    m.i2c_stop();
    ew(7'h10, 8'hc3);
    ew(7'h10, 8'h3c);
    m.i2c_start();
    wb(8'hba, 1'b1);
    check({15'h0, hit}, 16'h0);
    m.i2c_stop();
    check(16'(wq.size()), 16'h0);
    $display("test i2c_misc done");
    // ========
    // Four-wire stepped write, fixed read, three-wire stepped read
    m.spi_frame(8'h52, 2, tx);
    #100;
    ew(7'h12, 8'ha1);
    ew(7'h13, 8'hb2);
    m.spi_frame(8'h85, 2, tx);
    check({8'h0, m.rx[0]}, {8'h0, rv(7'h05)});
    check({8'h0, m.rx[1]}, {8'h0, rv(7'h05)});
    @(negedge clk);
    tw = 1'b1;
    m.spi_frame(8'he0, 2, tx);
    check({8'h0, m.rx[0]}, {8'h0, rv(7'h20)});
    check({8'h0, m.rx[1]}, {8'h0, rv(7'h21)});
    check(16'(wq.size()), 16'h0);
    $display("test spi done");
    wrap_up();
  end
endmodule
`default_nettype wire
